// ==== src/prm_reg_bank.v ====
// peripheral block register bank with relocation and interrupt mode select
`timescale 1ns/1ns
`include "prm_map.vh"
module prm_reg_bank #(
   parameter ADDR_W = 16
) (
   input wire sys_clk_i, // 50 mhz clock
   input wire sys_rst_i, // synchronous reset, high
   input wire io_cycle_i, // access is to i/o space
   input wire [ADDR_W-1:0] addr_i, // byte address from core
   input wire wr_i, // write strobe
   input wire rd_i, // read strobe
   input wire [15:0] wdata_i, // write data
   input wire [15:0] code_seg_i, // code segment value
   input wire [15:0] instruction_pointer_i, // start offset
   input wire [15:0] int_request_i, // pending requests from int unit
   input wire [15:0] in_service_i, // in-service bits from int unit
   input wire [15:0] poll_i, // poll answer from int unit
   output reg [15:0] rdata_o, // read data
   output reg hit_o, // last access hit the block
   output reg eoi_o, // end-of-interrupt command pulse
   output reg [15:0] eoi_data_o, // end-of-interrupt value
   output reg compat_interrupt_mode_o, // compatibility arrangement active
   output reg [15:0] reloc_o, // relocation register
   output reg [19:0] effective_start_address_o // computed start address
);
   // storage: 8 words per dma channel incl pointer highs, 5 chip selects,
   // 11 timer words, 16 interrupt words per mode
   reg [15:0] reloc_reg;
   reg [15:0] dma_reg [0:15];
   reg [15:0] cs_reg [0:4];
   reg [15:0] tmr_reg [0:11];
   reg [15:0] def_int_reg [0:15];
   reg [15:0] cmp_int_reg [0:15];
   reg [15:0] rdata_next;
   reg hit_next;
   wire [19:0] base_addr;
   wire in_block;
   wire [6:0] woff;
   wire mode_cmp;
   integer i;

   // base from low 12 relocation bits, i/o or memory per bit 12
   assign base_addr = {reloc_reg[11:0], 8'h00};
   assign in_block = (addr_i[ADDR_W-1:8] == base_addr[ADDR_W-1:8]) &&
      (io_cycle_i == ~reloc_reg[`PRM_MEMIO_BIT]);
   assign woff = addr_i[7:1];
   assign mode_cmp = reloc_reg[`PRM_MODE_BIT];

   // map a word offset to timer slot, or 15 when none
   function [3:0] tmr_idx;
      input [6:0] w;
      begin
         tmr_idx = 4'hf;
         if (w >= `PRM_OFS_T0 && w < `PRM_OFS_T0 + 7'h4)
            tmr_idx = {2'b00, w[1:0]};
         else if (w >= `PRM_OFS_T1 && w < `PRM_OFS_T1 + 7'h4)
            tmr_idx = {2'b01, w[1:0]};
         else if (w >= `PRM_OFS_T2 && w < `PRM_OFS_T2 + 7'h3)
            tmr_idx = {2'b10, w[1:0]}; // no max b for timer 2
      end
   endfunction

   // map a word offset to chip select slot, or 7 when none
   function [2:0] cs_idx;
      input [6:0] w;
      begin
         cs_idx = 3'h7;
         if (w >= `PRM_OFS_UPPER_SEL && w <= `PRM_OFS_PROG_SEL)
            cs_idx = w[2:0] - 3'h0;
      end
   endfunction

   // writes; dma/cs/timer storage independent of mode
   always @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         reloc_reg <= `PRM_RELOC_RESET;
         eoi_o <= 1'b0;
         eoi_data_o <= 16'h0000;
         for (i = 0; i < 16; i = i + 1)
         begin
            dma_reg[i] <= 16'h0000;
            def_int_reg[i] <= 16'h0000;
            cmp_int_reg[i] <= 16'h0000;
         end
         for (i = 0; i < 5; i = i + 1)
            cs_reg[i] <= 16'h0000;
         for (i = 0; i < 12; i = i + 1)
            tmr_reg[i] <= 16'h0000;
      end
      else
      begin
         eoi_o <= 1'b0;
         if (wr_i && in_block)
         begin
            if (woff == `PRM_OFS_RELOC)
               reloc_reg <= wdata_i;
            else if (woff[6:4] == 3'h6)
               dma_reg[woff[3:0]] <= wdata_i;
            else if (cs_idx(woff) != 3'h7)
               cs_reg[cs_idx(woff)] <= wdata_i;
            else if (tmr_idx(woff) != 4'hf)
               tmr_reg[tmr_idx(woff)] <= wdata_i;
            else if (woff[6:4] == 3'h1)
            begin
               if (woff[3:0] == `PRM_IOF_EOI)
               begin
                  eoi_o <= 1'b1;
                  eoi_data_o <= wdata_i;
               end
               else if (woff[3:0] == `PRM_IOF_POLL ||
                  woff[3:0] == `PRM_IOF_PSTAT ||
                  woff[3:0] == `PRM_IOF_INSVC ||
                  woff[3:0] == `PRM_IOF_REQ)
                  eoi_data_o <= eoi_data_o; // status write ignored
               else if (mode_cmp)
                  cmp_int_reg[woff[3:0]] <= wdata_i;
               else
                  def_int_reg[woff[3:0]] <= wdata_i;
            end
         end
      end
   end

   // read decode
   always @*
   begin
      rdata_next = 16'h0000;
      hit_next = in_block && (rd_i || wr_i);
      if (woff == `PRM_OFS_RELOC)
         rdata_next = reloc_reg;
      else if (woff[6:4] == 3'h6)
      begin
         // pointer high words read back only 4 bits, upper 12 as zero
         if (woff[1] && !woff[2])
            rdata_next = {12'h000, dma_reg[woff[3:0]][3:0]};
         else
            rdata_next = dma_reg[woff[3:0]];
      end
      else if (cs_idx(woff) != 3'h7)
         rdata_next = cs_reg[cs_idx(woff)];
      else if (tmr_idx(woff) != 4'hf)
         rdata_next = tmr_reg[tmr_idx(woff)];
      else if (woff[6:4] == 3'h1)
      begin
         if (woff[3:0] == `PRM_IOF_EOI)
            rdata_next = `PRM_UNDEF_DATA;
         else if (woff[3:0] == `PRM_IOF_INSVC)
            rdata_next = in_service_i;
         else if (woff[3:0] == `PRM_IOF_REQ)
            rdata_next = int_request_i;
         else if (!mode_cmp && woff[3:0] == `PRM_IOF_POLL)
            rdata_next = poll_i;
         else if (!mode_cmp && woff[3:0] == `PRM_IOF_PSTAT)
            rdata_next = poll_i;
         else if (mode_cmp)
            rdata_next = cmp_int_reg[woff[3:0]];
         else
            rdata_next = def_int_reg[woff[3:0]];
      end
   end

   // registered outputs
   always @(posedge sys_clk_i)
   begin
      if (sys_rst_i)
      begin
         rdata_o <= 16'h0000;
         hit_o <= 1'b0;
         compat_interrupt_mode_o <= 1'b0;
         reloc_o <= `PRM_RELOC_RESET;
         effective_start_address_o <= 20'h00000;
      end
      else
      begin
         rdata_o <= (rd_i && in_block) ? rdata_next : 16'h0000;
         hit_o <= hit_next;
         compat_interrupt_mode_o <= mode_cmp;
         reloc_o <= reloc_reg;
         effective_start_address_o <= {4'h0, instruction_pointer_i} +
            {code_seg_i, 4'h0};
      end
   end
endmodule

// ==== src/prm_map.vh ====
// constants for the peripheral block relocation register bank
`ifndef PRM_MAP_VH
`define PRM_MAP_VH
`define PRM_RELOC_RESET 16'h20ff
`define PRM_MODE_BIT 14
`define PRM_MEMIO_BIT 12
`define PRM_UNDEF_DATA 16'hffff
// word offsets (byte offset divided by two) within the 256-byte block
`define PRM_OFS_RELOC 7'h7f
`define PRM_OFS_DMA1 7'h68
`define PRM_OFS_DMA0 7'h60
`define PRM_OFS_UPPER_SEL 7'h50
`define PRM_OFS_LOWER_SEL 7'h51
`define PRM_OFS_PERIPH_SEL 7'h52
`define PRM_OFS_MID_SEL 7'h53
`define PRM_OFS_PROG_SEL 7'h54
`define PRM_OFS_T0 7'h28
`define PRM_OFS_T1 7'h2c
`define PRM_OFS_T2 7'h30
`define PRM_OFS_INT 7'h10
`define PRM_INT_WORDS 16
// interrupt sub-offsets within the interrupt group
`define PRM_IOF_EOI 4'h1
`define PRM_IOF_POLL 4'h2
`define PRM_IOF_PSTAT 4'h3
`define PRM_IOF_MASK 4'h4
`define PRM_IOF_PMASK 4'h5
`define PRM_IOF_INSVC 4'h6
`define PRM_IOF_REQ 4'h7
`define PRM_IOF_STATE 4'h8
`define PRM_IOF_VECT 4'h0
`endif

// ==== testbench/prm_reg_bank_chk.sv ====
// assertion checker for the peripheral block register bank
`timescale 1ns/1ns
module prm_reg_bank_chk #(
   parameter ADDR_W = 16
) (
   input wire sys_clk_i, sys_rst_i, io_cycle_i, wr_i, rd_i, // clock and strobes
   input wire hit_o, eoi_o, compat_interrupt_mode_o, // pulses and mode
   input wire [ADDR_W-1:0] addr_i, // byte address
   input wire [15:0] wdata_i, code_seg_i, instruction_pointer_i, // inputs
   input wire [15:0] int_request_i, rdata_o, eoi_data_o, reloc_o, // data
   input wire [19:0] effective_start_address_o // start address
);
   // block hit and word offset as the core sees them
   wire blk = io_cycle_i && !reloc_o[12] && addr_i[15:8] == reloc_o[7:0];
   wire [6:0] ofs = addr_i[7:1];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_reloc_wr;
      wr_i && blk && ofs == 7'h7f;
   endsequence
   sequence s_eoi_wr;
      wr_i && blk && ofs == 7'h11;
   endsequence
   a_reset_reloc: assert property (
      $fell(sys_rst_i) |-> reloc_o == 16'h20ff) else $error("bad reset reloc");
   a_reset_mode: assert property (
      $fell(sys_rst_i) |-> !compat_interrupt_mode_o) else $error("bad mode");
   a_start_addr: assert property (
      !$past(sys_rst_i) |-> effective_start_address_o ==
      {4'h0, $past(instruction_pointer_i)} + {$past(code_seg_i), 4'h0})
      else $error("bad start address");
   a_eoi_unreadable: assert property (
      rd_i && blk && ofs == 7'h11 |=> rdata_o == 16'hffff)
      else $error("eoi read not undefined");
   a_read_hit: assert property (
      rd_i && blk |=> hit_o) else $error("read missed block");
   a_idle_quiet: assert property (
      !rd_i && !wr_i |=> !hit_o && !eoi_o && rdata_o == 16'h0000)
      else $error("output without access");
   a_eoi_pulse: assert property (
      s_eoi_wr |=> eoi_o && eoi_data_o == $past(wdata_i))
      else $error("eoi command lost");
   a_mode_switch: assert property (
      s_reloc_wr |=> ##1 (reloc_o == $past(wdata_i, 2) &&
      compat_interrupt_mode_o == reloc_o[14]))
      else $error("relocation write not applied");
   a_request_read: assert property (
      rd_i && blk && ofs == 7'h17 |=> rdata_o == $past(int_request_i))
      else $error("request read wrong");
endmodule
bind prm_reg_bank prm_reg_bank_chk #(.ADDR_W(ADDR_W)) chk_u (.*);

// ==== testbench/prm_reg_bank_test.sv ====
// self-checking bench for the peripheral block register bank
`timescale 1ns/1ns
module prm_reg_bank_test;
   reg sys_clk_i = 0, sys_rst_i = 1, io_cycle_i = 1, wr_i = 0, rd_i = 0;
   reg [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, code_seg_i = 16'h1234;
   reg [15:0] instruction_pointer_i = 16'h0056, int_request_i = 16'ha5a5;
   reg [15:0] in_service_i = 16'h0f0f, poll_i = 16'h8003;
   wire [15:0] rdata_o, eoi_data_o, reloc_o;
   wire hit_o, eoi_o, compat_interrupt_mode_o;
   wire [19:0] effective_start_address_o;
   integer failures = 0, total_checks = 0, i, t = 0;
   reg [47:0] tbl [0:5]; // address, write value, read value
   prm_reg_bank dut_u (.*);
   initial forever #10 sys_clk_i = ~sys_clk_i;
   // compare one result and count it
   task chk(input [19:0] got, input [19:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp)
         begin
            failures = failures + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // one strobe cycle; the answer stands just after the taking edge
   task acc(input w, input [15:0] a, input [15:0] d);
      begin
         @(posedge sys_clk_i);
         #2 wr_i = w;
         rd_i = !w;
         addr_i = a;
         wdata_i = d;
         @(posedge sys_clk_i);
         #2 wr_i = 0;
         rd_i = 0;
      end
   endtask
   task rd(input [15:0] a, input [15:0] e);
      begin
         acc(0, a, 16'h0000);
         chk(rdata_o, e);
      end
   endtask
   task tdone;
      begin
         t = t + 1;
         $display("test %0d done", t);
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   // watchdog at 1000 cycles, well beyond the under 100 cycles the tests need
   initial
   begin
      #20000 failures = failures + 1;
      end_sim;
   end
   // main sequence
   initial
   begin
      tbl[0] = {16'hffc4, 16'hffff, 16'h000f};
      tbl[1] = {16'hffd6, 16'hffff, 16'h000f};
      tbl[2] = {16'hffa0, 16'h1234, 16'h1234};
      tbl[3] = {16'hffa8, 16'habcd, 16'habcd};
      tbl[4] = {16'hff56, 16'h5a5a, 16'h5a5a};
      tbl[5] = {16'hff66, 16'h5a5a, 16'h0000};
      repeat (3) @(posedge sys_clk_i);
      #2 sys_rst_i = 0;
      chk(reloc_o, 20'h020ff);
      chk(compat_interrupt_mode_o, 0);
      @(posedge sys_clk_i);
      #2 chk(effective_start_address_o, 20'h12396);
      tdone;
      rd(16'hff2e, 16'ha5a5);
      chk(hit_o, 1);
      rd(16'hff24, 16'h8003);
      rd(16'hff22, 16'hffff);
      acc(1, 16'hff22, 16'h8000);
      chk(eoi_o, 1);
      chk(eoi_data_o, 16'h8000);
      acc(1, 16'hff2e, 16'h0000);
      rd(16'hff2e, 16'ha5a5);
      io_cycle_i = 0;
      rd(16'hff2e, 16'h0000);
      chk(hit_o, 0);
      io_cycle_i = 1;
      for (i = 0; i < 6; i = i + 1)
         acc(1, tbl[i][47:32], tbl[i][31:16]);
      for (i = 0; i < 6; i = i + 1)
         rd(tbl[i][47:32], tbl[i][15:0]);
      acc(1, 16'hff34, 16'h0007);
      rd(16'hff34, 16'h0007);
      rd(16'hff26, 16'h8003);
      tdone;
      acc(1, 16'hfffe, 16'h40ff);
      @(posedge sys_clk_i);
      #2 chk(compat_interrupt_mode_o, 1);
      rd(16'hff22, 16'hffff);
      for (i = 0; i < 6; i = i + 1)
         rd(tbl[i][47:32], tbl[i][15:0]);
      rd(16'hff34, 16'h0000);
      acc(1, 16'hff34, 16'h0005);
      rd(16'hff34, 16'h0005);
      acc(1, 16'hff20, 16'h0020);
      rd(16'hff20, 16'h0020);
      acc(1, 16'hfffe, 16'h40fe);
      rd(16'hff2e, 16'h0000);
      rd(16'hfe2e, 16'ha5a5);
      acc(1, 16'hfefe, 16'h20ff);
      @(posedge sys_clk_i);
      #2 chk(compat_interrupt_mode_o, 0);
      chk(reloc_o, 20'h020ff);
      rd(16'hff34, 16'h0007);
      tdone;
      end_sim;
   end
endmodule
